// >>> lin_status_error_flags.sv
`timescale 1ns/1ps

// Functional notes
// [RULE1] Status bit 7 shows whether activity is currently seen on the bus.
// [RULE2] Slave: status bit 6 set after four seconds without bus activity, not asleep.
// [RULE3] Slave: abort bit 5 set on break during a frame, or on stop.
// [RULE4] Abort cleared by a break that cuts no pending transmission short.
// [RULE5] Slave: data request bit 4 set once an identifier is received.
// [RULE6] Interrupt pending bit 3 stays set until clear-interrupt control is written.
// [RULE7] Error summary bit 2 set on any error, cleared only by clear-errors.
// [RULE8] Wakeup bit 1 set while sending wakeup or after receiving one.
// [RULE9] Done bit 0 cleared at frame start, set at frame completion.
// [RULE10] Slave: error bit 4 set when sync field edges are out of tolerance.
// [RULE11] Slave: error bit 3 set on identifier parity failure.
// [RULE12] Error bit 2 set when master awaits a slave response that never comes.
// [RULE13] Timeout also when the slave expects data and none appears.
// [RULE14] Timeout when a frame exceeds the maximum frame length.
// [RULE15] Timeout if no acknowledge or stop before first byte after identifier.
// [RULE16] Error bit 1 set on received checksum mismatch.
// [RULE17] Error bit 0 set when read-back bit differs from sent bit.
// [RULE18] Error register bits 7:5 read zero, writes ignored.
// [RULE19] Writing one to control bit 2 clears all error flags; reads zero.
// [RULE20] Writing stop blocks slave frame processing until the next break.
// [RULE21] Data acknowledge set by software, cleared by the device itself.
// [RULE22] Done, error or data request setting raises interrupt pending and request.
// [RULE23] All status and error flags clear on reset.
module lin_status_error_flags #(
  parameter int unsigned IDLE_TIMEOUT_CYCLES = lin_status_pkg::IDLE_TIMEOUT_CYCLES,
  parameter int unsigned RESP_TIMEOUT_CYCLES = lin_status_pkg::RESP_TIMEOUT_CYCLES,
  parameter int unsigned FRAME_MAX_CYCLES = lin_status_pkg::FRAME_MAX_CYCLES,
  parameter int unsigned ACTIVE_HOLD_CYCLES = lin_status_pkg::ACTIVE_HOLD_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic lin_rx_in,
  input wire logic slave_mode_in,
  input wire logic bus_sleep_in,
  input wire logic frame_start_in,
  input wire logic frame_done_in,
  input wire logic break_in,
  input wire logic id_rx_in,
  input wire logic byte_rx_in,
  input wire logic response_wait_in,
  input wire logic sync_err_in,
  input wire logic parity_err_in,
  input wire logic checksum_err_in,
  input wire logic tx_bit_strobe_in,
  input wire logic tx_bit_in,
  input wire logic wakeup_tx_in,
  input wire logic wakeup_rx_in,
  output logic irq_out,
  output logic data_ack_out,
  output logic frame_block_out
);

  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    logic active;
    logic idle_to;
    logic abort;
    logic dreq;
    logic irq_pend;
    logic err_sum;
    logic wakeup;
    logic done;
    logic [lin_status_pkg::ERR_WIDTH-1:0] err;
    logic data_acknowledge_control;
    logic block;
    logic ack_pending;
    logic in_frame;
    logic [7:0] rdata;
  } flags_state_t;

  flags_state_t state_reg;
  flags_state_t state_next;

  logic idle_expire;
  logic resp_expire;
  logic frame_expire;
  logic quiet_expire;
  logic rx_idle;
  logic wr_ctrl;
  logic stop_wr;
  logic data_acknowledge_control_wr;
  logic clear_interrupt_control_wr;
  logic clear_errors_control_wr;
  logic slave_break;
  logic ack_missed;
  logic bit_mismatch;
  logic [lin_status_pkg::ERR_WIDTH-1:0] err_event;
  logic [7:0] status_view;
  logic [7:0] error_view;
  logic [7:0] ctrl_view;
  logic slave_live;
  logic done_rise;
  logic err_rise;
  logic dreq_rise;

  // The bus pin is asynchronous; only rx_sync is looked at by logic
  assign rx_idle = (state_reg.rx_sync == lin_status_pkg::RX_IDLE_LEVEL);

  assign wr_ctrl = reg_wr_in && (reg_addr_in == lin_status_pkg::CTRL_OFFSET);
  assign stop_wr = wr_ctrl && reg_wdata_in[lin_status_pkg::CTRL_STOP_BIT] && slave_mode_in;
  assign data_acknowledge_control_wr = wr_ctrl && reg_wdata_in[lin_status_pkg::CTRL_DATA_ACKNOWLEDGE_CONTROL_BIT] && slave_mode_in;
  assign clear_interrupt_control_wr = wr_ctrl && reg_wdata_in[lin_status_pkg::CTRL_CLEAR_INTERRUPT_CONTROL_BIT];
  assign clear_errors_control_wr = wr_ctrl && reg_wdata_in[lin_status_pkg::CTRL_CLEAR_ERRORS_CONTROL_BIT];

  assign slave_break = break_in && slave_mode_in;

  // Slave-only causes are ignored while a stop holds the slave off the bus
  assign slave_live = slave_mode_in && !state_reg.block;

  // A data byte finishing while software has neither acknowledged nor stopped
  assign ack_missed = byte_rx_in && state_reg.ack_pending; // [RULE15]

  // Read-back sampled at the same point the frame engine strobes its sent bit
  assign bit_mismatch = tx_bit_strobe_in && (tx_bit_in != state_reg.rx_sync); // [RULE17]

  always_comb begin
    err_event = '0;
    if (sync_err_in && slave_live) begin
      err_event[lin_status_pkg::ERR_SYNC_BIT] = 1'b1; // [RULE10]
    end
    if (parity_err_in && slave_live) begin
      err_event[lin_status_pkg::ERR_PARITY_BIT] = 1'b1; // [RULE11]
    end
    if (resp_expire) begin
      err_event[lin_status_pkg::ERR_TIMEOUT_BIT] = 1'b1; // [RULE12] [RULE13]
    end
    if (frame_expire) begin
      err_event[lin_status_pkg::ERR_TIMEOUT_BIT] = 1'b1; // [RULE14]
    end
    if (ack_missed) begin
      err_event[lin_status_pkg::ERR_TIMEOUT_BIT] = 1'b1; // [RULE15]
    end
    if (checksum_err_in) begin
      err_event[lin_status_pkg::ERR_CHECKSUM_BIT] = 1'b1; // [RULE16]
    end
    if (bit_mismatch) begin
      err_event[lin_status_pkg::ERR_BIT_BIT] = 1'b1; // [RULE17]
    end
  end

  // Interrupt follows rising flags only; a flag that merely stays set does not re-arm it
  assign done_rise = frame_done_in && !state_reg.done; // [RULE22]
  assign err_rise = (|err_event) && !state_reg.err_sum; // [RULE22]
  assign dreq_rise = id_rx_in && slave_live && !state_reg.dreq; // [RULE22]

  // Counts while the engine waits for response bytes, master or slave
  lin_cycle_timer #(
    .LIMIT(RESP_TIMEOUT_CYCLES)
  ) resp_timer (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .run_in(response_wait_in),
    .expire_out(resp_expire)
  );

  lin_cycle_timer #(
    .LIMIT(FRAME_MAX_CYCLES)
  ) frame_timer (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .run_in(state_reg.in_frame),
    .expire_out(frame_expire)
  );

  // Idle count restarts on every dominant level and stops once the flag is up
  lin_cycle_timer #(
    .LIMIT(IDLE_TIMEOUT_CYCLES)
  ) idle_timer (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .run_in(slave_mode_in && !bus_sleep_in && rx_idle && !state_reg.idle_to),
    .expire_out(idle_expire)
  );

  // Activity lingers for a short quiet period so recessive bits inside a frame do not drop it
  lin_cycle_timer #(
    .LIMIT(ACTIVE_HOLD_CYCLES)
  ) quiet_timer (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .run_in(state_reg.active && rx_idle),
    .expire_out(quiet_expire)
  );

  always_comb begin
    status_view = lin_status_pkg::STATUS_RESET;
    status_view[lin_status_pkg::ST_ACTIVE_BIT] = state_reg.active;
    status_view[lin_status_pkg::ST_IDLE_BIT] = state_reg.idle_to;
    status_view[lin_status_pkg::ST_ABORT_BIT] = state_reg.abort;
    status_view[lin_status_pkg::ST_DREQ_BIT] = state_reg.dreq;
    status_view[lin_status_pkg::ST_IRQ_BIT] = state_reg.irq_pend;
    status_view[lin_status_pkg::ST_ERROR_BIT] = state_reg.err_sum;
    status_view[lin_status_pkg::ST_WAKEUP_BIT] = state_reg.wakeup;
    status_view[lin_status_pkg::ST_DONE_BIT] = state_reg.done;
  end

  assign error_view = {lin_status_pkg::ERR_UNUSED_VALUE, state_reg.err}; // [RULE18]

  // Stop, clear-interrupt and clear-errors are strobes and always read zero
  always_comb begin
    ctrl_view = lin_status_pkg::READ_IDLE_VALUE;
    ctrl_view[lin_status_pkg::CTRL_DATA_ACKNOWLEDGE_CONTROL_BIT] = state_reg.data_acknowledge_control; // [RULE19] [RULE20]
  end

  always_comb begin
    state_next = state_reg;

    state_next.rx_meta = lin_rx_in;
    state_next.rx_sync = state_reg.rx_meta;

    if (!rx_idle) begin
      state_next.active = 1'b1; // [RULE1]
    end else if (quiet_expire) begin
      state_next.active = 1'b0; // [RULE1]
    end

    if (!rx_idle || bus_sleep_in || !slave_mode_in) begin
      state_next.idle_to = 1'b0;
    end else if (idle_expire) begin
      state_next.idle_to = 1'b1; // [RULE2]
    end

    // Open between start and done; abort and the frame timer judge a pending transmission by it
    if (frame_start_in) begin
      state_next.in_frame = 1'b1;
    end else if (frame_done_in) begin
      state_next.in_frame = 1'b0;
    end

    if (slave_break && !state_reg.in_frame) begin
      state_next.abort = 1'b0; // [RULE4]
    end
    if ((slave_break && state_reg.in_frame) || stop_wr) begin
      state_next.abort = 1'b1; // [RULE3]
    end

    // Stop written in the same cycle as a break wins, so the block holds to the next break
    if (break_in) begin
      state_next.block = 1'b0; // [RULE20]
    end
    if (stop_wr) begin
      state_next.block = 1'b1; // [RULE20]
    end

    if (break_in || frame_start_in) begin
      state_next.dreq = 1'b0; // [RULE5]
    end
    if (id_rx_in && slave_live) begin
      state_next.dreq = 1'b1; // [RULE5]
    end

    if (break_in || frame_done_in || byte_rx_in || data_acknowledge_control_wr || stop_wr) begin
      state_next.ack_pending = 1'b0; // [RULE15]
    end
    if (id_rx_in && slave_live) begin
      state_next.ack_pending = 1'b1; // [RULE15]
    end

    // The engine samples the acknowledge level; it is dropped once the byte has come in
    if (byte_rx_in || frame_done_in || break_in) begin
      state_next.data_acknowledge_control = 1'b0; // [RULE21]
    end
    if (data_acknowledge_control_wr) begin
      state_next.data_acknowledge_control = 1'b1; // [RULE21]
    end

    // Set wins, so a start and a completion in one cycle leave the frame reported done
    if (frame_start_in) begin
      state_next.done = 1'b0; // [RULE9]
    end
    if (frame_done_in) begin
      state_next.done = 1'b1; // [RULE9]
    end

    // Wakeup stays up after sending ends, until the next frame starts
    if (frame_start_in) begin
      state_next.wakeup = 1'b0; // [RULE8]
    end
    if (wakeup_tx_in || wakeup_rx_in) begin
      state_next.wakeup = 1'b1; // [RULE8]
    end

    // New errors landing in the clearing cycle survive the clear
    if (clear_errors_control_wr) begin
      state_next.err = lin_status_pkg::ERROR_RESET; // [RULE19]
      state_next.err_sum = 1'b0; // [RULE7] [RULE19]
    end
    state_next.err = state_next.err | err_event;
    if (|err_event) begin
      state_next.err_sum = 1'b1; // [RULE7]
    end

    if (clear_interrupt_control_wr) begin
      state_next.irq_pend = 1'b0; // [RULE6]
    end
    if (done_rise || err_rise || dreq_rise) begin
      state_next.irq_pend = 1'b1; // [RULE6] [RULE22]
    end

    state_next.rdata = lin_status_pkg::READ_IDLE_VALUE;
    if (reg_rd_in) begin
      case (reg_addr_in)
        lin_status_pkg::CTRL_OFFSET: begin
          state_next.rdata = ctrl_view;
        end
        lin_status_pkg::STATUS_OFFSET: begin
          state_next.rdata = status_view;
        end
        lin_status_pkg::ERROR_OFFSET: begin
          state_next.rdata = error_view; // [RULE18]
        end
        default: begin
          state_next.rdata = lin_status_pkg::READ_IDLE_VALUE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '0; // [RULE23]
      state_reg.rx_meta <= lin_status_pkg::RX_IDLE_LEVEL;
      state_reg.rx_sync <= lin_status_pkg::RX_IDLE_LEVEL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_out = state_reg.rdata;
  assign irq_out = state_reg.irq_pend; // [RULE22]
  assign data_ack_out = state_reg.data_acknowledge_control;
  assign frame_block_out = state_reg.block;

endmodule : lin_status_error_flags

// >>> lin_status_pkg.sv
package lin_status_pkg;

  // Register indices on the indirect register port
  localparam logic [7:0] CTRL_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h09;
  localparam logic [7:0] ERROR_OFFSET = 8'h0A;

  // Control register bit positions (write side effects, except data acknowledge which also reads back)
  localparam int unsigned CTRL_STOP_BIT = 7;
  localparam int unsigned CTRL_DATA_ACKNOWLEDGE_CONTROL_BIT = 4;
  localparam int unsigned CTRL_CLEAR_INTERRUPT_CONTROL_BIT = 3;
  localparam int unsigned CTRL_CLEAR_ERRORS_CONTROL_BIT = 2;

  // Status register bit positions
  localparam int unsigned ST_ACTIVE_BIT = 7;
  localparam int unsigned ST_IDLE_BIT = 6;
  localparam int unsigned ST_ABORT_BIT = 5;
  localparam int unsigned ST_DREQ_BIT = 4;
  localparam int unsigned ST_IRQ_BIT = 3;
  localparam int unsigned ST_ERROR_BIT = 2;
  localparam int unsigned ST_WAKEUP_BIT = 1;
  localparam int unsigned ST_DONE_BIT = 0;

  // Error register bit positions; bits 7:5 are unused
  localparam int unsigned ERR_SYNC_BIT = 4;
  localparam int unsigned ERR_PARITY_BIT = 3;
  localparam int unsigned ERR_TIMEOUT_BIT = 2;
  localparam int unsigned ERR_CHECKSUM_BIT = 1;
  localparam int unsigned ERR_BIT_BIT = 0;
  localparam int unsigned ERR_WIDTH = 5;
  localparam logic [2:0] ERR_UNUSED_VALUE = 3'h0;

  // Values after reset
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [4:0] ERROR_RESET = 5'h00;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;
  localparam logic RX_IDLE_LEVEL = 1'b1;

  // Timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned IDLE_TIMEOUT_S = 4;
  localparam int unsigned IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_S * CLK_HZ;
  localparam int unsigned RESP_TIMEOUT_US = 10_000;
  localparam int unsigned RESP_TIMEOUT_CYCLES = RESP_TIMEOUT_US * CLK_PER_US;
  localparam int unsigned FRAME_MAX_US = 15_000;
  localparam int unsigned FRAME_MAX_CYCLES = FRAME_MAX_US * CLK_PER_US;
  localparam int unsigned ACTIVE_HOLD_US = 1_000;
  localparam int unsigned ACTIVE_HOLD_CYCLES = ACTIVE_HOLD_US * CLK_PER_US;

endpackage : lin_status_pkg

// >>> lin_cycle_timer.sv
`timescale 1ns/1ps

module lin_cycle_timer #(
  parameter int unsigned LIMIT = 16
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  output logic expire_out
);

  localparam logic [31:0] LAST = 32'(LIMIT - 1);

  typedef struct packed {
    logic [31:0] cnt;
    logic fired;
    logic expire;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  // Counts while run is high; one expiry pulse per run, restarted once run drops
  always_comb begin
    state_next = state_reg;
    state_next.expire = 1'b0;
    if (!run_in) begin
      state_next.cnt = 32'h0000_0000;
      state_next.fired = 1'b0;
    end else if (!state_reg.fired) begin
      if (state_reg.cnt == LAST) begin
        state_next.fired = 1'b1;
        state_next.expire = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign expire_out = state_reg.expire;

endmodule : lin_cycle_timer

// >>> lin_status_error_flags_assertions.sv
`timescale 1ns/1ps

module lin_status_error_flags_assertions (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic slave_mode_in,
  input wire logic frame_start_in,
  input wire logic frame_done_in,
  input wire logic break_in,
  input wire logic byte_rx_in,
  input wire logic irq_out,
  input wire logic data_ack_out,
  input wire logic frame_block_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);
  logic ctrl_wr;
  logic ack_clear;
  assign ctrl_wr = reg_wr_in && (reg_addr_in == lin_status_pkg::CTRL_OFFSET);
  assign ack_clear = byte_rx_in || frame_done_in || break_in;
  sequence s_read_then_quiet;
    reg_rd_in ##1 !reg_rd_in;
  endsequence
  // Done can only rise after a start or reset has cleared it
  sequence s_start_then_done;
    frame_start_in ##1 (frame_done_in && !frame_start_in);
  endsequence
  a_read_one_cycle: assert property (s_read_then_quiet |=> reg_rdata_out == lin_status_pkg::READ_IDLE_VALUE)
    else $error("read data stood longer than one cycle");
  a_err_upper_zero: assert property (reg_rd_in && reg_addr_in == lin_status_pkg::ERROR_OFFSET |=>
    reg_rdata_out[7:5] == lin_status_pkg::ERR_UNUSED_VALUE) else $error("unused error bits not zero");
  a_done_raises_irq: assert property (s_start_then_done |=> irq_out)
    else $error("completion did not raise the interrupt");
  a_irq_sticky: assert property (irq_out && !(ctrl_wr && reg_wdata_in[3]) |=> irq_out)
    else $error("interrupt dropped without clear write");
  a_dack_set: assert property (ctrl_wr && reg_wdata_in[4] && slave_mode_in && !ack_clear |=> data_ack_out)
    else $error("acknowledge write not taken");
  a_dack_auto_clear: assert property (data_ack_out && ack_clear && !(ctrl_wr && reg_wdata_in[4]) |=> !data_ack_out)
    else $error("acknowledge not cleared by the device");
  a_stop_blocks: assert property (ctrl_wr && reg_wdata_in[7] && slave_mode_in |=> frame_block_out)
    else $error("stop write did not block processing");
  a_break_unblocks: assert property (frame_block_out && break_in && !(ctrl_wr && reg_wdata_in[7]) |=> !frame_block_out)
    else $error("break did not release the block");
endmodule : lin_status_error_flags_assertions

bind lin_status_error_flags lin_status_error_flags_assertions lin_status_error_flags_assertions_i (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .slave_mode_in(slave_mode_in),
  .frame_start_in(frame_start_in), .frame_done_in(frame_done_in), .break_in(break_in), .byte_rx_in(byte_rx_in),
  .irq_out(irq_out), .data_ack_out(data_ack_out), .frame_block_out(frame_block_out));

// >>> lin_bus_node_model.sv
`timescale 1ns/1ps

module lin_bus_node_model (
  input wire logic ref_clk_in,
  input wire logic go_in,
  input wire logic [7:0] hold_in,
  output logic lin_rx_out
);
  logic [7:0] left_reg = 8'h00;
  always_ff @(posedge ref_clk_in) begin
    if (go_in) begin
      left_reg <= hold_in;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  // Released bus returns to recessive through the pull-up
  assign lin_rx_out = (left_reg == 8'h00);
endmodule : lin_bus_node_model

// >>> lin_status_error_flags_tb_top.sv
`timescale 1ns/1ps

module lin_status_error_flags_tb_top;
  localparam int RESP_N = 20;
  localparam int FRAME_N = 40;
  localparam int HOLD_N = 10;
  localparam int IDLE_N = 50;
  localparam logic [7:0] CT = lin_status_pkg::CTRL_OFFSET;
  localparam logic [7:0] ST = lin_status_pkg::STATUS_OFFSET;
  localparam logic [7:0] ER = lin_status_pkg::ERROR_OFFSET;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic lin_rx;
  logic slave_mode = 1'b0;
  logic bus_sleep = 1'b1;
  logic resp_wait = 1'b0;
  logic tx_bit = 1'b1;
  logic wakeup_tx = 1'b0;
  logic bus_go = 1'b0;
  logic [9:0] evt = 10'h000;
  logic irq_out;
  logic data_ack_out;
  logic frame_block_out;
  logic [7:0] d;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 ref_clk_in = ~ref_clk_in;

  lin_bus_node_model lin_bus_node_model_i (.ref_clk_in(ref_clk_in), .go_in(bus_go), .hold_in(8'h05),
    .lin_rx_out(lin_rx));

  lin_status_error_flags #(.IDLE_TIMEOUT_CYCLES(IDLE_N), .RESP_TIMEOUT_CYCLES(RESP_N),
    .FRAME_MAX_CYCLES(FRAME_N), .ACTIVE_HOLD_CYCLES(HOLD_N)) lin_status_error_flags_i (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .lin_rx_in(lin_rx),
    .slave_mode_in(slave_mode), .bus_sleep_in(bus_sleep), .frame_start_in(evt[0]), .frame_done_in(evt[1]),
    .break_in(evt[2]), .id_rx_in(evt[3]), .byte_rx_in(evt[4]), .response_wait_in(resp_wait),
    .sync_err_in(evt[5]), .parity_err_in(evt[6]), .checksum_err_in(evt[7]), .tx_bit_strobe_in(evt[9]),
    .tx_bit_in(tx_bit), .wakeup_tx_in(wakeup_tx), .wakeup_rx_in(evt[8]), .irq_out(irq_out),
    .data_ack_out(data_ack_out), .frame_block_out(frame_block_out));

  task print_verdict();
    $display("mismatches %0d, checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask : rd

  task bitchk(input logic [7:0] a, input int b, input logic e);
    rd(a);
    check({7'h00, d[b]}, {7'h00, e});
  endtask : bitchk

  task pulse(input int k);
    @(posedge ref_clk_in);
    evt <= 10'h001 << k;
    @(posedge ref_clk_in);
    evt <= 10'h000;
  endtask : pulse

  task pulse_pair(input int k1, input int k2);
    @(posedge ref_clk_in);
    evt <= 10'h001 << k1;
    @(posedge ref_clk_in);
    evt <= 10'h001 << k2;
    @(posedge ref_clk_in);
    evt <= 10'h000;
  endtask : pulse_pair

  task t_reset();
    rd(ST);
    check(d, lin_status_pkg::STATUS_RESET);
    rd(ER);
    check(d, 8'h00);
    wr(ER, 8'hFF);
    rd(ER);
    check(d, 8'h00);
    rd(8'h3C);
    check(d, 8'h00);
  endtask : t_reset

  task t_done();
    pulse(0);
    bitchk(ST, 0, 1'b0);
    pulse(1);
    bitchk(ST, 0, 1'b1);
    bitchk(ST, 3, 1'b1);
    check({7'h00, irq_out}, 8'h01);
    wr(CT, 8'h08);
    bitchk(ST, 3, 1'b0);
    check({7'h00, irq_out}, 8'h00);
    pulse(0);
    bitchk(ST, 0, 1'b0);
    pulse_pair(0, 1);
    bitchk(ST, 0, 1'b1);
    check({7'h00, irq_out}, 8'h01);
  endtask : t_done

  task t_errors();
    pulse(5);
    bitchk(ER, 4, 1'b0);
    slave_mode <= 1'b1;
    for (int k = 5; k <= 7; k++) begin
      pulse(k);
      bitchk(ER, (k == 5) ? 4 : (k == 6) ? 3 : 1, 1'b1);
      wr(CT, 8'h08);
      bitchk(ST, 2, 1'b1);
      wr(CT, 8'h04);
      rd(ER);
      check(d, 8'h00);
      bitchk(ST, 2, 1'b0);
    end
    tx_bit <= 1'b1;
    pulse(9);
    bitchk(ER, 0, 1'b0);
    tx_bit <= 1'b0;
    pulse(9);
    bitchk(ER, 0, 1'b1);
    tx_bit <= 1'b1;
    wr(CT, 8'h04);
  endtask : t_errors

  task t_timeout();
    for (int m = 0; m <= 1; m++) begin
      slave_mode <= m[0];
      resp_wait <= 1'b1;
      repeat (RESP_N - 6) @(posedge ref_clk_in);
      bitchk(ER, 2, 1'b0);
      repeat (6) @(posedge ref_clk_in);
      resp_wait <= 1'b0;
      bitchk(ER, 2, 1'b1);
      wr(CT, 8'h04);
    end
    pulse(0);
    repeat (FRAME_N + 4) @(posedge ref_clk_in);
    bitchk(ER, 2, 1'b1);
    pulse(1);
    wr(CT, 8'h04);
    pulse(3);
    bitchk(ST, 4, 1'b1);
    pulse(4);
    bitchk(ER, 2, 1'b1);
    wr(CT, 8'h04);
    pulse(0);
    bitchk(ST, 4, 1'b0);
    pulse(3);
    wr(CT, 8'h10);
    @(negedge ref_clk_in);
    check({7'h00, data_ack_out}, 8'h01);
    pulse(4);
    @(negedge ref_clk_in);
    check({7'h00, data_ack_out}, 8'h00);
    bitchk(ER, 2, 1'b0);
    pulse(1);
  endtask : t_timeout

  task t_abort();
    pulse(0);
    pulse(2);
    bitchk(ST, 5, 1'b1);
    pulse(1);
    pulse(2);
    bitchk(ST, 5, 1'b0);
    wr(CT, 8'h80);
    bitchk(ST, 5, 1'b1);
    check({7'h00, frame_block_out}, 8'h01);
    rd(CT);
    check(d, 8'h00);
    pulse(3);
    bitchk(ST, 4, 1'b0);
    pulse(2);
    @(negedge ref_clk_in);
    check({7'h00, frame_block_out}, 8'h00);
  endtask : t_abort

  task t_bus();
    bus_sleep <= 1'b0;
    @(posedge ref_clk_in);
    bus_go <= 1'b1;
    @(posedge ref_clk_in);
    bus_go <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    bitchk(ST, 7, 1'b1);
    repeat (HOLD_N + 8) @(posedge ref_clk_in);
    bitchk(ST, 7, 1'b0);
    bitchk(ST, 6, 1'b0);
    repeat (IDLE_N) @(posedge ref_clk_in);
    bitchk(ST, 6, 1'b1);
    bus_sleep <= 1'b1;
    bitchk(ST, 6, 1'b0);
    pulse(8);
    bitchk(ST, 1, 1'b1);
    pulse(0);
    bitchk(ST, 1, 1'b0);
    wakeup_tx <= 1'b1;
    bitchk(ST, 1, 1'b1);
    wakeup_tx <= 1'b0;
    pulse(1);
  endtask : t_bus

  initial begin
    repeat (10) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_done();
    t_errors();
    t_timeout();
    t_abort();
    t_bus();
    print_verdict();
  end
endmodule : lin_status_error_flags_tb_top
